// *** verilog/arsq_pkg.sv ***
// Contract
// RULE_01 - one external read address sequence serves accumulation reads and offline readout.
// RULE_02 - ram write addresses come from the internal generator, not the external bus.
// RULE_03 - cycles 512 to 515 of each transform cycle form the offline access gap; the code holds the counter at 515, so the gap lasts until i_INIT.
// RULE_04 - ram banks swap every 131 msec; one accumulates, other reads out.
// RULE_05 - controller presents offline strobe and read address at access cycles.
// RULE_06 - controller issues offline access once per 27 transform cycles.
// RULE_07 - each 36-bit result is read as two 18-bit halves per strobe; the code reads one half per strobe, chosen by half_result_select.
// RULE_08 - strobe rising edge latches card select, row, column, array, half select.
// RULE_09 - latched active card select enables addressed chip onto one internal bus.
// RULE_10 - controller steps baselines 0 to 209 in order.
// RULE_11 - controller decodes each baseline into row, column and card selects.
// RULE_12 - card numbers follow the four-by-four station block map, cards 0-14.
// RULE_13 - column select is vertical station index modulo four.
// RULE_14 - row select is horizontal station index modulo four.
// RULE_15 - two internal buses: columns 0 and 1 on one, 2 and 3 other.
// RULE_16 - both internal buses float while the readout strobe is high.
// RULE_17 - both internal buses float while the card is not selected.
// RULE_18 - unselected card holds output multiplexer at zero.
// RULE_19 - strobe high one clock, low seven; result valid next strobe cycle.
// RULE_20 - offline strobe at period 514, address at 513; clear blanks data.
// RULE_21 - output mux routes the selected column group bus to card output.
package arsq_pkg;
  localparam int unsigned HALF_W = 18;
  localparam int unsigned RESULT_W = 36;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [9:0] CYC_LAST = 10'h0_203;
  localparam logic [9:0] CYC_GAP_FIRST = 10'h0_200;
  localparam logic [9:0] CYC_ADDR = 10'h0_201;
  localparam logic [9:0] CYC_STROBE = 10'h0_202;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BANK_MS = 131;
  localparam int unsigned BANK_CYCLES = CLK_HZ / 1000 * BANK_MS;
  localparam logic [4:0] RD_PERIOD_M1 = 5'h0_1a;

  typedef struct packed {
    logic card_select_n;
    logic [1:0] row;
    logic [1:0] col;
    logic array_sel;
    logic half_result_select;
  } arsq_addr_t;

  typedef struct packed {
    logic [8:0] rd_addr;
    logic [8:0] wr_addr;
    logic bank;
  } arsq_ram_t;
endpackage

// *** verilog/arsq_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module arsq_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic push;
  logic pop;
  assign o_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign o_valid = wp_q != rp_q;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rp_q[AW-1:0]];
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= i_data;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // arsq_fifo
`default_nettype wire

// *** verilog/arsq_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module arsq_top #(
  parameter int unsigned BANK_CYCLES = arsq_pkg::BANK_CYCLES
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic i_INIT,
  input wire logic i_ACCUMULATOR_CLEAR,
  input wire logic i_OFFLINE_BANK_STROBE_N,
  input wire logic i_READOUT_CYCLE_STROBE,
  input wire logic i_CARD_SELECT_N,
  input wire logic [1:0] i_ROW,
  input wire logic [1:0] i_COL,
  input wire logic i_ARRAY,
  input wire logic i_HALF_RESULT_SELECT,
  input wire logic [8:0] i_EXTERNAL_READ_ADDRESS,
  input wire logic [35:0] i_CHIP_RESULT,
  output logic [8:0] o_RAM_RD_ADDR,
  output logic [8:0] o_RAM_WR_ADDR,
  output logic o_BANK,
  output logic o_GAP,
  output logic o_CAPTURE,
  output logic [3:0] o_CHIP_ROW,
  output logic [3:0] o_CHIP_COL,
  output logic o_CHIP_ARRAY,
  output logic [17:0] o_BUSA,
  output logic o_BUSA_OE,
  output logic [17:0] o_BUSB,
  output logic o_BUSB_OE,
  output logic [17:0] o_DOUT,
  output logic o_DOUT_OE,
  output logic o_DOUT_VALID,
  input wire logic i_DOUT_READY
);
  // ************************************************************
  // input synchronisers (three stages)
  // ************************************************************
  logic [2:0] str_s_q;
  logic [2:0] mwe_s_q;
  logic str_q;
  logic mwe_n_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      str_s_q <= 3'h0;
      mwe_s_q <= 3'h7;
    end else begin
      str_s_q <= {str_s_q[1:0], i_READOUT_CYCLE_STROBE};
      mwe_s_q <= {mwe_s_q[1:0], i_OFFLINE_BANK_STROBE_N};
    end
  end
  // both strobes last one clock, so an agreement filter would swallow them
  assign str_q = str_s_q[2];
  assign mwe_n_q = mwe_s_q[2];

  // ************************************************************
  // transform cycle counter and offline gap
  // ************************************************************
  logic [9:0] cyc_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN || i_INIT) begin
      cyc_q <= 10'h0_000;
    end else if (cyc_q != arsq_pkg::CYC_LAST) begin
      cyc_q <= cyc_q + 10'h0_001;
    end
  end
  assign o_GAP = cyc_q >= arsq_pkg::CYC_GAP_FIRST; // [RULE_03]

  // ************************************************************
  // ram addressing and bank swap
  // ************************************************************
  logic [8:0] wr_q;
  logic [31:0] bank_cnt_q;
  logic bank_q;
  logic [8:0] rd_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      rd_q <= 9'h0_00;
    end else begin
      rd_q <= i_EXTERNAL_READ_ADDRESS; // [RULE_01]
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN || i_INIT) begin
      wr_q <= 9'h0_00;
    end else if (!o_GAP && cyc_q[0]) begin
      wr_q <= wr_q + 9'h0_01; // [RULE_02]
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      bank_cnt_q <= 32'h0000_0000;
      bank_q <= 1'b0;
    end else if (bank_cnt_q == 32'(BANK_CYCLES - 1)) begin
      bank_cnt_q <= 32'h0000_0000;
      bank_q <= ~bank_q; // [RULE_04]
    end else begin
      bank_cnt_q <= bank_cnt_q + 32'h0000_0001;
    end
  end
  assign o_RAM_RD_ADDR = rd_q;
  assign o_RAM_WR_ADDR = wr_q;
  assign o_BANK = bank_q;

  // ************************************************************
  // offline capture into storage register
  // ************************************************************
  logic [35:0] store_q;
  logic cap_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      store_q <= 36'h0_0000_0000;
      cap_q <= 1'b0;
    end else begin
      cap_q <= !mwe_n_q;
      if (!mwe_n_q) begin
        store_q <= i_ACCUMULATOR_CLEAR ? 36'h0_0000_0000 : i_CHIP_RESULT; // [RULE_20]
      end
    end
  end
  assign o_CAPTURE = cap_q;

  // ************************************************************
  // readout address latch on strobe rising edge
  // ************************************************************
  logic str_d1_q;
  logic rise;
  arsq_pkg::arsq_addr_t adr_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      str_d1_q <= 1'b0;
    end else begin
      str_d1_q <= str_q;
    end
  end
  assign rise = str_q && !str_d1_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      adr_q <= '{card_select_n: 1'b1, default: '0};
    end else if (rise) begin
      adr_q <= '{card_select_n: i_CARD_SELECT_N, row: i_ROW, col: i_COL,
                 array_sel: i_ARRAY, half_result_select: i_HALF_RESULT_SELECT}; // [RULE_08]
    end
  end

  // ************************************************************
  // chip enable decode and internal buses
  // ************************************************************
  function automatic logic [3:0] onehot2(input logic [1:0] v);
    onehot2 = 4'h1 << v;
  endfunction
  logic sel;
  logic [17:0] half;
  assign sel = !adr_q.card_select_n;
  assign half = adr_q.half_result_select ? store_q[35:18] : store_q[17:0]; // [RULE_07]
  assign o_CHIP_ROW = sel ? onehot2(adr_q.row) : 4'h0;
  assign o_CHIP_COL = sel ? onehot2(adr_q.col) : 4'h0; // [RULE_09]
  assign o_CHIP_ARRAY = adr_q.array_sel;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      o_BUSA <= 18'h0_0000;
      o_BUSB <= 18'h0_0000;
    end else begin
      o_BUSA <= half;
      o_BUSB <= half;
    end
  end
  assign o_BUSA_OE = sel && !str_q && !adr_q.col[1]; // [RULE_15] [RULE_16] [RULE_17]
  assign o_BUSB_OE = sel && !str_q && adr_q.col[1]; // [RULE_15] [RULE_16] [RULE_17]

  // ************************************************************
  // card output multiplexer through fifo
  // ************************************************************
  logic [17:0] mux;
  logic push;
  logic fifo_rdy;
  logic [17:0] fifo_dat;
  assign mux = !sel ? 18'h0_0000 : (adr_q.col[1] ? o_BUSB : o_BUSA); // [RULE_18] [RULE_21]
  assign push = sel && rise;
  arsq_fifo #(
    .WIDTH(arsq_pkg::HALF_W),
    .DEPTH(arsq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rstn(I_RSTN),
    .i_valid(push),
    .o_ready(fifo_rdy),
    .i_data(mux),
    .o_valid(o_DOUT_VALID),
    .i_ready(i_DOUT_READY),
    .o_data(fifo_dat)
  );
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      o_DOUT <= 18'h0_0000;
    end else begin
      o_DOUT <= fifo_dat;
    end
  end
  assign o_DOUT_OE = sel;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_gap;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (cyc_q == 10'h1ff && !i_INIT) |=> o_GAP;
  endproperty
  a_gap: assert property (p_gap) else $error("gap not entered"); // [RULE_03]
  property p_busoff;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      str_q |-> !o_BUSA_OE && !o_BUSB_OE;
  endproperty
  a_busoff: assert property (p_busoff) else $error("bus driven in strobe"); // [RULE_16]
  property p_unsel;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      !sel |-> (mux == 18'h0_0000) && !o_BUSA_OE && !o_BUSB_OE;
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected card active"); // [RULE_17]
  property p_onebus;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      !(o_BUSA_OE && o_BUSB_OE);
  endproperty
  a_onebus: assert property (p_onebus) else $error("both buses driven"); // [RULE_15]
  property p_latch;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      rise |=> adr_q.card_select_n == $past(i_CARD_SELECT_N);
  endproperty
  a_latch: assert property (p_latch) else $error("select not latched"); // [RULE_08]
  property p_hold;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      !rise |=> $stable(adr_q);
  endproperty
  a_hold: assert property (p_hold) else $error("address changed off edge"); // [RULE_08]
  property p_blank;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!mwe_n_q && i_ACCUMULATOR_CLEAR) |=> store_q == 36'h0_0000_0000;
  endproperty
  a_blank: assert property (p_blank) else $error("clear did not blank"); // [RULE_20]
  property p_enable;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (sel && !str_q) |-> (o_BUSA_OE || o_BUSB_OE) && (o_CHIP_COL != 4'h0);
  endproperty
  a_enable: assert property (p_enable) else $error("chip not enabled"); // [RULE_09]
  property p_route;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (sel && adr_q.col[1]) |-> mux == o_BUSB;
  endproperty
  a_route: assert property (p_route) else $error("wrong bus routed"); // [RULE_21]
  property p_wrstill;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (o_GAP && !i_INIT) |=> $stable(wr_q);
  endproperty
  a_wrstill: assert property (p_wrstill) else $error("write addr moved in gap"); // [RULE_02]
  property p_swap;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (bank_cnt_q == 32'(BANK_CYCLES - 1)) |=> o_BANK != $past(o_BANK);
  endproperty
  a_swap: assert property (p_swap) else $error("bank did not swap"); // [RULE_04]
  property p_bankhold;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (bank_cnt_q != 32'(BANK_CYCLES - 1)) |=> $stable(o_BANK);
  endproperty
  a_bankhold: assert property (p_bankhold) else $error("bank swapped early"); // [RULE_04]
  property p_rdcopy;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      I_RSTN |=> o_RAM_RD_ADDR == $past(i_EXTERNAL_READ_ADDRESS);
  endproperty
  a_rdcopy: assert property (p_rdcopy) else $error("read addr not taken"); // [RULE_01]
  property p_wrstep;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!o_GAP && cyc_q[0] && !i_INIT) |=> o_RAM_WR_ADDR == $past(o_RAM_WR_ADDR) + 9'h0_01;
  endproperty
  a_wrstep: assert property (p_wrstep) else $error("write addr did not step"); // [RULE_02]
  property p_capture;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!mwe_n_q && !i_ACCUMULATOR_CLEAR) |=> (store_q == $past(i_CHIP_RESULT)) && o_CAPTURE;
  endproperty
  a_capture: assert property (p_capture) else $error("result not captured"); // [RULE_20]
  property p_half;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      I_RSTN |=> o_BUSA == ($past(adr_q.half_result_select) ?
                            $past(store_q[35:18]) : $past(store_q[17:0]));
  endproperty
  a_half: assert property (p_half) else $error("wrong half on bus"); // [RULE_07]
  property p_chipoff;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      !sel |-> (o_CHIP_ROW == 4'h0) && (o_CHIP_COL == 4'h0);
  endproperty
  a_chipoff: assert property (p_chipoff) else $error("chip enabled unselected"); // [RULE_09]
  property p_push;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (rise && sel && fifo_rdy) |=> o_DOUT_VALID;
  endproperty
  a_push: assert property (p_push) else $error("selected result not queued"); // [RULE_21]
  property p_gapend;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (o_GAP && !i_INIT) |=> o_GAP;
  endproperty
  a_gapend: assert property (p_gapend) else $error("gap left without init"); // [RULE_03]
  c_sel: cover property (@(posedge I_CORE_CLK) disable iff (!I_RSTN) rise ##1 sel);
  c_cap: cover property (@(posedge I_CORE_CLK) disable iff (!I_RSTN) cap_q);
  c_busb: cover property (@(posedge I_CORE_CLK) disable iff (!I_RSTN) o_BUSB_OE);
  c_full: cover property (@(posedge I_CORE_CLK) disable iff (!I_RSTN) !fifo_rdy);
endmodule // arsq_top
`default_nettype wire

// *** tb/arsq_mcc_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module arsq_mcc_model #(
  parameter int CARD = 0
) (
  input wire logic i_clk,
  output logic o_strobe,
  output logic o_card_select_n,
  output logic [1:0] o_row,
  output logic [1:0] o_col,
  output logic o_array,
  output logic o_half
);
  initial begin
    o_strobe = 1'b0;
    o_card_select_n = 1'b1;
    {o_row, o_col, o_array, o_half} = 6'h00;
  end
  // *****************************
  // one readout round per baseline
  // *****************************
  task automatic run(input int bl, input logic half);
    int h = 0;
    int v = bl;
    int offs[5] = '{0, 5, 9, 12, 14};
    while (v >= 20 - h) begin
      v = v - (20 - h);
      h = h + 1;
    end
    v = v + h;
    @(posedge i_clk);
    #5;
    o_strobe = 1'b1;
    o_card_select_n = (offs[h / 4] + v / 4 - h / 4) != CARD;
    o_row = 2'(h % 4);
    o_col = 2'(v % 4);
    o_array = 1'(bl % 2);
    o_half = half;
    @(posedge i_clk);
    #5;
    o_strobe = 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule // arsq_mcc_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`define ARSQ_CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module tb_top;
  typedef struct {int bl; logic half; int card; int row; int col;} arsq_row_t;
  localparam int CARD = 0;
  logic clk = 1'b0, rstn = 1'b0, init = 1'b0, obs_n = 1'b1, rdy = 1'b1, clr = 1'b0, sel, bprev;
  logic [8:0] ext = 9'h000, rd_addr, wr_addr, w;
  logic [35:0] res = 36'h0_0000_0000;
  wire logic strobe, cs_n, arr, half;
  wire logic [1:0] row, col;
  logic bank, gap, capture, chip_arr, a_oe, b_oe, dout_oe, dvalid;
  logic [3:0] chip_row, chip_col;
  logic [17:0] busa, busb, dout;
  int fails = 0, n_compared = 0, zcnt = 0, ccnt = 0, bcnt = 0, pops = 0;
  arsq_row_t rows[8] = '{'{0, 0, 0, 0, 0}, '{5, 1, 1, 0, 1}, '{19, 0, 4, 0, 3},
    '{20, 1, 0, 1, 1}, '{40, 0, 0, 2, 3}, '{2, 1, 0, 0, 2}, '{74, 0, 5, 0, 0},
    '{209, 1, 14, 3, 3}};

  arsq_top #(.BANK_CYCLES(100)) i_arsq_top (.I_CORE_CLK(clk), .I_RSTN(rstn), .i_INIT(init),
    .i_ACCUMULATOR_CLEAR(clr), .i_OFFLINE_BANK_STROBE_N(obs_n), .i_READOUT_CYCLE_STROBE(strobe),
    .i_CARD_SELECT_N(cs_n), .i_ROW(row), .i_COL(col), .i_ARRAY(arr), .i_HALF_RESULT_SELECT(half),
    .i_EXTERNAL_READ_ADDRESS(ext), .i_CHIP_RESULT(res), .o_RAM_RD_ADDR(rd_addr),
    .o_RAM_WR_ADDR(wr_addr), .o_BANK(bank), .o_GAP(gap), .o_CAPTURE(capture),
    .o_CHIP_ROW(chip_row), .o_CHIP_COL(chip_col), .o_CHIP_ARRAY(chip_arr), .o_BUSA(busa),
    .o_BUSA_OE(a_oe), .o_BUSB(busb), .o_BUSB_OE(b_oe), .o_DOUT(dout), .o_DOUT_OE(dout_oe),
    .o_DOUT_VALID(dvalid), .i_DOUT_READY(rdy));
  arsq_mcc_model #(.CARD(CARD)) i_arsq_mcc_model (.i_clk(clk), .o_strobe(strobe),
    .o_card_select_n(cs_n), .o_row(row), .o_col(col), .o_array(arr), .o_half(half));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (!a_oe && !b_oe) zcnt++;
    if (capture) ccnt++;
    if (bank !== bprev) bcnt++;
    if (dvalid && rdy) pops++;
    bprev = bank;
  end

  task conclude;
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    conclude;
  end
  // *****************************
  // main sequence
  // *****************************
  initial begin
    repeat (5) @(posedge clk);
    #5;
    `ARSQ_CHK("reset", 8'h00, {a_oe, b_oe, dout_oe, dvalid, chip_row})
    repeat (5) @(posedge clk);
    #5;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    #5;
    for (int k = 0; k < 8; k++) begin
      res = 36'h9_8765_4321 + 36'(k * 4099);
      obs_n = 1'b0;
      @(posedge clk);
      #5;
      obs_n = 1'b1;
      repeat (2) begin
        #5;
        zcnt = 0;
        i_arsq_mcc_model.run(rows[k].bl, rows[k].half);
      end
      #5;
      sel = rows[k].card == CARD;
      `ARSQ_CHK("float", sel ? 1 : 8, zcnt)
      `ARSQ_CHK("chip_row", sel ? 4'h1 << rows[k].row : 4'h0, chip_row)
      `ARSQ_CHK("chip_col", sel ? 4'h1 << rows[k].col : 4'h0, chip_col)
      `ARSQ_CHK("oe", {sel && rows[k].col < 2, sel && rows[k].col > 1, sel}, {a_oe, b_oe, dout_oe})
      `ARSQ_CHK("array", 1'(rows[k].bl % 2), chip_arr)
      if (sel) `ARSQ_CHK("bus", rows[k].half ? res[35:18] : res[17:0], rows[k].col < 2 ? busa : busb)
    end
    rdy = 1'b0;
    for (int k = 0; k < 18; k++) i_arsq_mcc_model.run(0, 1'(k % 2));
    #5;
    `ARSQ_CHK("stall", 1'b1, dvalid)
    `ARSQ_CHK("head", res[17:0], dout)
    pops = 0;
    rdy = 1'b1;
    repeat (40) @(posedge clk);
    #5;
    `ARSQ_CHK("drained", 16, pops)
    `ARSQ_CHK("empty", 1'b0, dvalid)
    init = 1'b1;
    @(posedge clk);
    #5;
    init = 1'b0;
    repeat (505) @(posedge clk);
    #5;
    `ARSQ_CHK("gap_off", 1'b0, gap)
    repeat (7) @(posedge clk);
    #5;
    ext = 9'h1a5;
    ccnt = 0;
    @(posedge clk);
    #5;
    obs_n = 1'b0;
    w = wr_addr;
    `ARSQ_CHK("gap_on", 1'b1, gap)
    `ARSQ_CHK("rd_addr", 9'h1a5, rd_addr)
    @(posedge clk);
    #5;
    obs_n = 1'b1;
    `ARSQ_CHK("wr_hold", w, wr_addr)
    repeat (8) @(posedge clk);
    #5;
    `ARSQ_CHK("capture", 1, ccnt)
    `ARSQ_CHK("held", res[35:18], busa)
    clr = 1'b1;
    obs_n = 1'b0;
    @(posedge clk);
    #5;
    obs_n = 1'b1;
    repeat (4) @(posedge clk);
    #5;
    clr = 1'b0;
    `ARSQ_CHK("blank", 18'h0_0000, busa)
    bcnt = 0;
    repeat (1000) @(posedge clk);
    #5;
    `ARSQ_CHK("bank", 10, bcnt)
    conclude;
  end
endmodule // tb_top
`default_nettype wire
